//--- core/vpic_pkg.sv
// vpic_pkg: shared constants and carrier types of the vectored priority irq controller.
// assumes one system clock; peripheral requests arrive from logic on that same clock.
package vpic_pkg;

    // channel and priority geometry
    localparam int NUM_CH      = 32;
    localparam int CH_W        = 5;
    localparam int PRIO_W      = 4;
    localparam int STACK_DEPTH = 15;
    localparam int EXT_LINES   = 16;
    localparam int NUM_FIQ     = 2;

    // fixed source routing
    localparam int EXT_CHAN      = 5;
    localparam int FIQ0_SRC_CHAN = 0;   // timer 0 global
    localparam int FIQ1_SRC_CHAN = 4;   // watchdog
    localparam logic [31:0] RESERVED_MASK = 32'h19C0_0000;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL  = 12'h000;
    localparam logic [11:0] OFS_CICR  = 12'h004;
    localparam logic [11:0] OFS_CURRENT_PRIORITY_REGISTER  = 12'h008;
    localparam logic [11:0] OFS_VBASE = 12'h010;
    localparam logic [11:0] OFS_IVR   = 12'h018;
    localparam logic [11:0] OFS_FIQ   = 12'h01C;
    localparam logic [11:0] OFS_IER   = 12'h020;
    localparam logic [11:0] OFS_IPR   = 12'h040;
    localparam logic [11:0] OFS_SIR0  = 12'h060;
    localparam logic [11:0] OFS_SIR31 = 12'h0DC;

    // field positions
    localparam int CTRL_IRQ_EN  = 0;
    localparam int CTRL_FIQ_EN  = 1;
    localparam int FIQ_PEND_LSB = 2;
    localparam int SIR_ADDR_LSB = 16;

    // value of every control bit after reset
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [0:0] {
        FSM_READY = 1'b0,
        FSM_WAIT  = 1'b1
    } vpic_fsm_type;

    typedef struct packed {
        logic [CH_W-1:0]   chan;
        logic [PRIO_W-1:0] prio;
    } vpic_ctx_type;

    typedef struct packed {
        logic [15:0]       addr;
        logic [PRIO_W-1:0] prio;
    } vpic_sir_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } vpic_apb_req_type;

    typedef struct packed {
        vpic_fsm_type              fsm;
        logic                      irqEn;
        logic                      fiqEn;
        logic [15:0]               vbase;
        vpic_ctx_type              cur;
        logic [NUM_CH-1:0]         ier;
        logic [NUM_CH-1:0]         pending_bits_register;
        logic [NUM_FIQ-1:0]        fier;
        logic [NUM_FIQ-1:0]        fipr;
        logic                      ackFlag;
        vpic_ctx_type              ack;
        logic [31:0]               prdata;
        vpic_sir_type [NUM_CH-1:0] sir;
    } vpic_state_type;

endpackage

//--- core/vpic_prio_decoder.sv
// vpic_prio_decoder: combinational winner search over pending channels.
// assumes req already carries only enabled, pending channels.
`timescale 1ns/1ps
`default_nettype none
module vpic_prio_decoder #(
    parameter int NUM_CH = 32
) (
    input  wire logic [NUM_CH-1:0]                    req,
    input  wire logic [NUM_CH-1:0][vpic_pkg::PRIO_W-1:0] level,
    output logic                                      found,
    output logic [$clog2(NUM_CH)-1:0]                 chan,
    output logic [vpic_pkg::PRIO_W-1:0]               prio
);
    localparam int CW = $clog2(NUM_CH);

    if (NUM_CH < 2 || NUM_CH > 32) begin : g_chk
        $error("vpic_prio_decoder: NUM_CH must lie in 2..32");
    end

    // upward scan with >= so a higher channel takes an equal level
    always_comb begin
        found = 1'b0;
        chan  = '0;
        prio  = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (req[i] && (!found || level[i] >= prio)) begin
                found = 1'b1;
                chan  = CW'(i);
                prio  = level[i];
            end
        end
    end
endmodule
`default_nettype wire

//--- core/vpic_nest_stack.sv
// vpic_nest_stack: lifo of saved channel and priority for nested service.
// assumes push and pop are single-cycle pulses; push wins if both arrive, pop if the stack is full.
`timescale 1ns/1ps
`default_nettype none
module vpic_nest_stack #(
    parameter int DEPTH = 15
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   push,
    input  wire logic                   pop,
    input  wire vpic_pkg::vpic_ctx_type pushData,
    output vpic_pkg::vpic_ctx_type      top,
    output logic                        empty,
    output logic                        full
);
    localparam int SPW = $clog2(DEPTH + 1);

    if (DEPTH < 1 || DEPTH > 15) begin : g_chk
        $error("vpic_nest_stack: DEPTH must lie in 1..15");
    end

    typedef struct packed {
        logic [SPW-1:0]                           sp;
        vpic_pkg::vpic_ctx_type [DEPTH-1:0]       mem;
    } vpic_stack_state_type;

    vpic_stack_state_type stk_reg;
    vpic_stack_state_type stk_next;

    assign empty = (stk_reg.sp == '0);
    assign full  = (stk_reg.sp == SPW'(DEPTH));
    assign top   = empty ? '0 : stk_reg.mem[SPW'(stk_reg.sp - 1'b1)];

    // a full stack drops the push: priorities cap nesting at depth anyway
    always_comb begin
        stk_next = stk_reg;
        if (push && !full) begin
            stk_next.mem[stk_reg.sp] = pushData;
            stk_next.sp              = SPW'(stk_reg.sp + 1'b1);
        end else if (pop && !empty) begin
            stk_next.sp = SPW'(stk_reg.sp - 1'b1);
        end
    end

    // empty after reset
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stk_reg <= '0;
        end else begin
            stk_reg <= stk_next;
        end
    end
endmodule
`default_nettype wire

//--- core/vpic_controller.sv
// vpic_controller: vectored priority irq controller with apb register slave.
// assumes peripheral and external line requests are levels on clk; apb on clk.
// Operation
// - thirty-two maskable channels; all but the five reserved ones drive the irq request line
// - each irq channel has a programmable priority of sixteen levels
// - nesting stack holds up to fifteen saved contexts
// - two maskable fiq channels, no priority and no vector
// - winner's routine address appears in the vector register at 0x18
// - sixteen external lines are merged onto channel five
// - disabled channels never become pending nor arbitrate
// - irq raised only for a priority strictly above the current one
// - accepting an irq pushes the previous context onto the stack
// - accepting an irq loads the current priority with the winner's
// - fixed source per channel; channels 22,23,24,27,28 stay silent
// - fiq0 fed by timer 0 global, fiq1 by the watchdog
// - the two fiq sources still raise their ordinary irq channels
// - fiq pending bits are readable
// - irq path is decoder, two-state machine and stack
// - equal priority: higher channel number wins
// - vector read while waiting releases irq and starts the push
// - pending bits clear on written one, zero leaves them
// - clearing the served channel's pending bit pops the stack
`timescale 1ns/1ps
`default_nettype none
module vpic_controller #(
    parameter int STACK_DEPTH = vpic_pkg::STACK_DEPTH
) (
    input  wire logic                                clk,
    input  wire logic                                rstn,
    input  wire vpic_pkg::vpic_apb_req_type          apbReq,
    output logic [31:0]                              prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic [vpic_pkg::NUM_CH-1:0]         periphReq,
    input  wire logic [vpic_pkg::EXT_LINES-1:0]      extLine,
    output logic                                     irqReq,
    output logic                                     fiqReq
);
    if (STACK_DEPTH != vpic_pkg::STACK_DEPTH) begin : g_chk
        $error("vpic_controller: stack depth must match fifteen priority levels");
    end

    vpic_pkg::vpic_state_type r_reg;
    vpic_pkg::vpic_state_type r_next;

    logic [vpic_pkg::NUM_CH-1:0]                      chanReq;
    logic [vpic_pkg::NUM_CH-1:0]                      arbReq;
    logic [vpic_pkg::NUM_CH-1:0][vpic_pkg::PRIO_W-1:0] levels;
    logic [vpic_pkg::NUM_FIQ-1:0]                     fiqSrc;
    logic                                             winFound;
    logic [vpic_pkg::CH_W-1:0]                        winChan;
    logic [vpic_pkg::PRIO_W-1:0]                      winPrio;
    logic                                             stackPush;
    logic                                             stackPop;
    vpic_pkg::vpic_ctx_type                           stackTop;
    logic                                             stackEmpty;
    logic                                             accessCyc;
    logic                                             wrAccess;
    logic                                             ivrAck;
    logic                                             iprWrite;
    logic [4:0]                                       sirIdx;

    // decodes a mapped word address; shared by error answer and write path
    function automatic logic isMapped(input logic [11:0] a);
        isMapped = (a[1:0] == 2'b00) &&
                   (a == vpic_pkg::OFS_CTRL  || a == vpic_pkg::OFS_CICR ||
                    a == vpic_pkg::OFS_CURRENT_PRIORITY_REGISTER  || a == vpic_pkg::OFS_VBASE ||
                    a == vpic_pkg::OFS_IVR   || a == vpic_pkg::OFS_FIQ ||
                    a == vpic_pkg::OFS_IER   || a == vpic_pkg::OFS_IPR ||
                    (a >= vpic_pkg::OFS_SIR0 && a <= vpic_pkg::OFS_SIR31));
    endfunction

    // source routing into channels
    always_comb begin
        chanReq = periphReq & ~vpic_pkg::RESERVED_MASK;
        chanReq[vpic_pkg::EXT_CHAN] = |extLine;
        fiqSrc = {periphReq[vpic_pkg::FIQ1_SRC_CHAN],
                  periphReq[vpic_pkg::FIQ0_SRC_CHAN]};
    end

    // only enabled pending channels enter arbitration
    assign arbReq = r_reg.pending_bits_register & r_reg.ier;

    // per-channel priority fields
    always_comb begin
        for (int i = 0; i < vpic_pkg::NUM_CH; i++) begin
            levels[i] = r_reg.sir[i].prio;
        end
    end

    // combinational winner search
    vpic_prio_decoder #(
        .NUM_CH (vpic_pkg::NUM_CH)
    ) u_decoder (
        .req    (arbReq),
        .level  (levels),
        .found  (winFound),
        .chan   (winChan),
        .prio   (winPrio)
    );

    // apb strobes
    assign accessCyc = apbReq.psel && apbReq.penable;
    assign wrAccess  = accessCyc && apbReq.pwrite && isMapped(apbReq.paddr);
    assign ivrAck    = accessCyc && !apbReq.pwrite && apbReq.paddr == vpic_pkg::OFS_IVR
                       && r_reg.fsm == vpic_pkg::FSM_WAIT;
    assign iprWrite  = wrAccess && apbReq.paddr == vpic_pkg::OFS_IPR;
    assign sirIdx    = 5'((apbReq.paddr - vpic_pkg::OFS_SIR0) >> 2);

    // push lands one cycle after the vector read; pop on served-bit clear
    assign stackPush = r_reg.ackFlag;
    assign stackPop  = iprWrite && apbReq.pwdata[r_reg.cur.chan] && !stackEmpty
                       && !r_reg.ackFlag;

    vpic_nest_stack #(
        .DEPTH    (STACK_DEPTH)
    ) u_stack (
        .clk      (clk),
        .rstn     (rstn),
        .push     (stackPush),
        .pop      (stackPop),
        .pushData (r_reg.cur),
        .top      (stackTop),
        .empty    (stackEmpty),
        .full     ()
    );

    // zero-wait slave; read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = accessCyc && !isMapped(apbReq.paddr);
    assign prdata  = r_reg.prdata;

    // request lines; the global enables only mask, the machine keeps running
    assign irqReq = r_reg.irqEn && r_reg.fsm == vpic_pkg::FSM_WAIT;
    assign fiqReq = r_reg.fiqEn && |(r_reg.fipr & r_reg.fier);

    // next-state of all controller state
    always_comb begin
        r_next = r_reg;

        // pending capture: set wins over a same-cycle clear
        r_next.pending_bits_register  = (r_reg.pending_bits_register & ~(iprWrite ? apbReq.pwdata : vpic_pkg::ZERO_WORD))
                      | (chanReq & r_reg.ier);
        r_next.fipr = r_reg.fipr | (fiqSrc & r_reg.fier);

        // register writes
        if (wrAccess) begin
            case (apbReq.paddr)
                vpic_pkg::OFS_CTRL: begin
                    r_next.irqEn = apbReq.pwdata[vpic_pkg::CTRL_IRQ_EN];
                    r_next.fiqEn = apbReq.pwdata[vpic_pkg::CTRL_FIQ_EN];
                end
                vpic_pkg::OFS_CURRENT_PRIORITY_REGISTER: begin
                    // may only be raised from the served channel's level
                    if (apbReq.pwdata[vpic_pkg::PRIO_W-1:0] >= r_reg.sir[r_reg.cur.chan].prio) begin
                        r_next.cur.prio = apbReq.pwdata[vpic_pkg::PRIO_W-1:0];
                    end
                end
                vpic_pkg::OFS_VBASE: begin
                    r_next.vbase = apbReq.pwdata[31:16];
                end
                vpic_pkg::OFS_FIQ: begin
                    r_next.fier = apbReq.pwdata[vpic_pkg::NUM_FIQ-1:0];
                    r_next.fipr = (r_reg.fipr
                                   & ~apbReq.pwdata[vpic_pkg::FIQ_PEND_LSB +: vpic_pkg::NUM_FIQ])
                                  | (fiqSrc & r_reg.fier);
                end
                vpic_pkg::OFS_IER: begin
                    r_next.ier = apbReq.pwdata;
                end
                default: begin
                    if (apbReq.paddr >= vpic_pkg::OFS_SIR0) begin
                        r_next.sir[sirIdx].addr = apbReq.pwdata[31:vpic_pkg::SIR_ADDR_LSB];
                        r_next.sir[sirIdx].prio = apbReq.pwdata[vpic_pkg::PRIO_W-1:0];
                    end
                end
            endcase
        end

        // pop restores the interrupted context
        if (stackPop) begin
            r_next.cur = stackTop;
        end

        // acknowledged context becomes current on the same edge that pushes the old one
        r_next.ackFlag = 1'b0;
        if (r_reg.ackFlag) begin
            r_next.cur = r_reg.ack;
        end

        // two-state request machine
        case (r_reg.fsm)
            vpic_pkg::FSM_READY: begin
                // held back while an ack is settling, else it would re-fire
                if (!r_reg.ackFlag && winFound && winPrio > r_reg.cur.prio) begin
                    r_next.fsm = vpic_pkg::FSM_WAIT;
                end
            end
            vpic_pkg::FSM_WAIT: begin
                if (ivrAck) begin
                    r_next.fsm      = vpic_pkg::FSM_READY;
                    r_next.ackFlag  = 1'b1;
                    r_next.ack.chan = winChan;
                    r_next.ack.prio = winPrio;
                end
            end
            default: begin
                r_next.fsm = vpic_pkg::FSM_READY;
            end
        endcase

        // read data captured in setup so it comes from a flip-flop
        if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
            case (apbReq.paddr)
                vpic_pkg::OFS_CTRL:  r_next.prdata = {30'h0000_0000, r_reg.fiqEn, r_reg.irqEn};
                vpic_pkg::OFS_CICR:  r_next.prdata = {27'h000_0000, r_reg.cur.chan};
                vpic_pkg::OFS_CURRENT_PRIORITY_REGISTER:  r_next.prdata = {28'h000_0000, r_reg.cur.prio};
                vpic_pkg::OFS_VBASE: r_next.prdata = {r_reg.vbase, 16'h0000};
                vpic_pkg::OFS_IVR:   r_next.prdata = {r_reg.vbase, r_reg.sir[winChan].addr};
                vpic_pkg::OFS_FIQ:   r_next.prdata = {28'h000_0000, r_reg.fipr, r_reg.fier};
                vpic_pkg::OFS_IER:   r_next.prdata = r_reg.ier;
                vpic_pkg::OFS_IPR:   r_next.prdata = r_reg.pending_bits_register;
                default: begin
                    if (isMapped(apbReq.paddr)) begin
                        r_next.prdata = {r_reg.sir[sirIdx].addr, 12'h000, r_reg.sir[sirIdx].prio};
                    end else begin
                        r_next.prdata = vpic_pkg::ZERO_WORD;
                    end
                end
            endcase
        end
    end

    // state register; all zero after reset, fsm ready, both lines low
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_irq_prio_higher: assert property ($rose(r_reg.fsm == vpic_pkg::FSM_WAIT)
        |-> $past(winFound && winPrio > r_reg.cur.prio))
        else $error("irq state entered without a higher priority winner");
    a_ivr_read_release: assert property (ivrAck |=> !irqReq ##1 stackPush == 1'b0)
        else $error("vector read did not release irq");
    a_push_after_ack: assert property (ivrAck |=> stackPush)
        else $error("no stack push one cycle after vector read");
    a_current_priority_register_load_ack: assert property (ivrAck |=> ##1 r_reg.cur.prio == $past(winPrio, 2)
        && r_reg.cur.chan == $past(winChan, 2))
        else $error("current priority not loaded from accepted channel");
    a_masked_no_win: assert property (winFound |-> r_reg.ier[winChan])
        else $error("disabled channel won arbitration");
    a_ext_to_ch5: assert property ((|extLine && r_reg.ier[vpic_pkg::EXT_CHAN])
        |=> r_reg.pending_bits_register[vpic_pkg::EXT_CHAN])
        else $error("external line did not set channel five");
    a_zero_write_keeps: assert property ((iprWrite && apbReq.pwdata == vpic_pkg::ZERO_WORD)
        |=> (r_reg.pending_bits_register & $past(r_reg.pending_bits_register)) == $past(r_reg.pending_bits_register))
        else $error("writing zero cleared a pending bit");
    a_pop_restores: assert property (stackPop |=> r_reg.cur == $past(stackTop))
        else $error("pop did not restore previous context");
    a_fiq_follows: assert property ((r_reg.fiqEn && periphReq[vpic_pkg::FIQ0_SRC_CHAN]
        && r_reg.fier[0]) |=> fiqReq)
        else $error("fiq not raised for enabled pending source");
    a_reserved_quiet: assert property ((r_reg.pending_bits_register & vpic_pkg::RESERVED_MASK)
        == vpic_pkg::ZERO_WORD)
        else $error("reserved channel became pending");

    c_ivr_ack:   cover property (ivrAck);
    c_nested:    cover property (stackPush && !stackEmpty);
    c_pop:       cover property (stackPop);
    c_fiq_both:  cover property (fiqReq && &r_reg.fipr);
endmodule
`default_nettype wire

//--- sim/vpic_core_model.sv
// vpic_core_model: processor core side, watching the irq and fiq request lines.
// assumes active-high request levels on clk; the vector fetch itself is made over apb.
`timescale 1ns/1ps
`default_nettype none
module vpic_core_model #(
    parameter int LAT = 3
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic irqReq,
    input  wire logic fiqReq,
    output logic      ackWant,
    output logic      fiqSeen
);
    int waitCnt;
    // slow core: asks for the vector only after irq has stood LAT cycles
    always_ff @(posedge clk) begin
        if (!rstn || !irqReq) begin
            waitCnt <= 0;
            ackWant <= 1'b0;
        end else begin
            waitCnt <= waitCnt + 1;
            ackWant <= (waitCnt >= LAT - 1);
        end
        fiqSeen <= rstn && fiqReq;  // no order between fiq sources
    end
endmodule
`default_nettype wire

//--- sim/vpic_controller_tb_top.sv
// vpic_controller_tb_top: self-checking bench against a behavioural irq model.
// assumes vpic_core_model as the core and a zero-wait apb slave in the design.
`timescale 1ns/1ps
`default_nettype none
module vpic_controller_tb_top;
    logic                       clk;
    logic                       rstn;
    vpic_pkg::vpic_apb_req_type req;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                periphReq;
    logic [15:0]                extLine;
    logic                       irqReq;
    logic                       fiqReq;
    logic                       ackWant;
    logic                       fiqSeen;
    logic [31:0]                rd;
    logic                       err;
    logic [31:0]                pend;
    int                         n_mismatch;
    int                         checks_done;
    int                         seed;
    int                         prio [32];
    logic [15:0]                vec [32];
    int                         curCh;
    int                         curPr;
    int                         stk [$];
    logic [11:0]                ofs [5] = '{vpic_pkg::OFS_CTRL, vpic_pkg::OFS_CURRENT_PRIORITY_REGISTER,
                                    vpic_pkg::OFS_IER, vpic_pkg::OFS_IPR, vpic_pkg::OFS_FIQ};

    vpic_controller #(.STACK_DEPTH(15)) vpic_controller_inst (.clk(clk), .rstn(rstn),
        .apbReq(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periphReq(periphReq), .extLine(extLine), .irqReq(irqReq), .fiqReq(fiqReq));
    vpic_core_model #(.LAT(3)) vpic_core_model_inst (.clk(clk), .rstn(rstn),
        .irqReq(irqReq), .fiqReq(fiqReq), .ackWant(ackWant), .fiqSeen(fiqSeen));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // bounded wait on a request line, sampled mid-cycle to stay clear of updates
    task automatic wait_lvl(input logic fiq, input logic lvl);
        int k;
        k = 0;
        while ((fiq ? fiqReq : irqReq) !== lvl && k < 20) begin
            @(negedge clk);
            k++;
        end
        chk(fiq ? "fiqReq" : "irqReq", fiq ? fiqReq : irqReq, lvl);
        // a used-up bound is already a mismatch; stop here
        if (k >= 20) give_verdict();
        // back onto the rising edge so later stimulus stays edge aligned
        @(posedge clk);
    endtask
    function automatic int win(input logic [31:0] p);
        int w;
        w = -1;
        for (int i = 0; i < 32; i++)
            if (p[i] && prio[i] > curPr && (w < 0 || prio[i] >= prio[w])) w = i;
        return w;
    endfunction
    task automatic sir(input int ch, input int pr, input logic [15:0] ad);
        prio[ch] = pr;
        vec[ch] = ad;
        apb(1'b1, vpic_pkg::OFS_SIR0 + 12'(4 * ch), {ad, 12'h000, 4'(pr)});
    endtask
    // vector fetch once the core asks; model pushes the old context
    task automatic ack;
        int k;
        int w;
        k = 0;
        while (ackWant !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        if (k >= 20) begin
            n_mismatch++;
            give_verdict();
        end
        w = win(pend);
        apb(1'b0, vpic_pkg::OFS_IVR, 32'h0);
        chk("vector", rd, {16'hABCD, vec[w]});
        stk.push_back(curCh * 16 + curPr);
        curCh = w;
        curPr = prio[w];
    endtask
    task automatic clr(input int ch);
        int v;
        apb(1'b1, vpic_pkg::OFS_IPR, 32'h1 << ch);
        pend[ch] = 1'b0;
        if (ch == curCh && stk.size() > 0) begin
            v = stk.pop_back();
            curCh = v / 16;
            curPr = v % 16;
        end
        idle(2);
    endtask
    task automatic cur_chk;
        apb(1'b0, vpic_pkg::OFS_CICR, 32'h0);
        chk("channel", rd, 32'(curCh));
        apb(1'b0, vpic_pkg::OFS_CURRENT_PRIORITY_REGISTER, 32'h0);
        chk("priority", rd, 32'(curPr));
    endtask

    // free-running system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // main sequence
    initial begin
        seed = 95884;
        n_mismatch = 0;
        checks_done = 0;
        curCh = 0;
        curPr = 0;
        pend = '0;
        rstn = 1'b0;
        req = '0;
        periphReq = '0;
        extLine = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0);
            chk("reset word", rd, vpic_pkg::ZERO_WORD);
        end
        chk("irqReq", irqReq, 1'b0);
        apb(1'b0, 12'h014, 32'h0);
        chk("pslverr", err, 1'b1);
        $display("test reset done");
        apb(1'b1, vpic_pkg::OFS_VBASE, 32'hABCD_0000);
        sir(3, 5, 16'h1234);
        sir(6, 5, 16'($random(seed)));
        sir(9, 7, 16'h9999);
        apb(1'b1, vpic_pkg::OFS_IER, 32'h0040_0269);
        apb(1'b1, vpic_pkg::OFS_CTRL, 32'h0000_0001);
        periphReq <= 32'h0000_0048;
        pend = 32'h0000_0048;
        wait_lvl(1'b0, 1'b1);
        ack();
        wait_lvl(1'b0, 1'b0);
        periphReq <= 32'h0;
        idle(2);
        cur_chk();
        idle(5);
        chk("irqReq", irqReq, 1'b0);
        $display("test arbitration done");
        periphReq <= 32'h0000_0200;
        pend[9] = 1'b1;
        wait_lvl(1'b0, 1'b1);
        ack();
        periphReq <= 32'h0;
        idle(2);
        cur_chk();
        apb(1'b1, vpic_pkg::OFS_IPR, 32'h0);
        apb(1'b0, vpic_pkg::OFS_IPR, 32'h0);
        chk("pending", rd, pend);
        // raise the served level, then try to drop it below the channel's own
        apb(1'b1, vpic_pkg::OFS_CURRENT_PRIORITY_REGISTER, 32'h0000_0008);
        apb(1'b1, vpic_pkg::OFS_CURRENT_PRIORITY_REGISTER, 32'h0000_0003);
        curPr = 8;
        cur_chk();
        clr(9);
        cur_chk();
        clr(3);
        cur_chk();
        clr(6);
        cur_chk();
        $display("test nesting done");
        extLine <= 16'h0001 | 16'($random(seed));
        periphReq <= 32'h0040_0002;
        idle(3);
        apb(1'b0, vpic_pkg::OFS_IPR, 32'h0);
        chk("pending", rd, 32'h0000_0020);
        extLine <= 16'h0;
        periphReq <= 32'h0;
        clr(5);
        $display("test masking done");
        apb(1'b1, vpic_pkg::OFS_FIQ, 32'h0000_0001);  // one fiq source only
        apb(1'b1, vpic_pkg::OFS_CTRL, 32'h0000_0003);
        periphReq <= 32'h0000_0001;
        wait_lvl(1'b1, 1'b1);
        idle(2);
        chk("fiqSeen", fiqSeen, 1'b1);
        apb(1'b0, vpic_pkg::OFS_FIQ, 32'h0);
        chk("fiq word", rd, 32'h0000_0005);
        apb(1'b0, vpic_pkg::OFS_IPR, 32'h0);
        chk("pending", rd, 32'h0000_0001);
        periphReq <= 32'h0;
        apb(1'b1, vpic_pkg::OFS_FIQ, 32'h0000_0005);
        wait_lvl(1'b1, 1'b0);
        chk("irqReq", irqReq, 1'b0);
        $display("test fiq done");
        give_verdict();
    end
endmodule
`default_nettype wire
